// *** rtl/ccd_pkg.sv ***
/*
 package for the cache, coprocessor and divide execute block.
 assumes a single core clock and a pipeline that supplies decoded operands.
*/
package ccd_pkg;
    // ---------------------------------------------------------------
    // instruction fields
    // ---------------------------------------------------------------
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam logic [5:0] OPC_CACHE = 6'h2F;
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [3:0] OPC_COP_HI = 4'h4;
    localparam int CO_BIT = 25;
    localparam logic [4:0] SUB_CF = 5'h02;
    localparam logic [4:0] SUB_CT = 5'h06;
    localparam logic [5:0] FN_DBG_RET = 6'h1F;
    localparam logic [5:0] FN_DIV = 6'h1A;
    localparam logic [5:0] FN_UNSIGNED_QUOTIENT_OP = 6'h1B;
    localparam logic [10:0] CTL_LOW_ZERO = 11'h000;
    localparam logic [18:0] DBG_RET_ZERO = 19'h00000;
    localparam int CACHE_OP_HI = 20;
    localparam int CACHE_OP_LO = 16;
    localparam logic [1:0] TGT_ICACHE = 2'h0;
    localparam logic [1:0] TGT_DCACHE = 2'h1;
    localparam logic [2:0] COP_IDX_INV = 3'h0;
    localparam logic [2:0] COP_IDX_LRU = 3'h1;
    localparam logic [2:0] COP_IDX_LOCK = 3'h2;
    localparam logic [2:0] COP_HIT_INV = 3'h4;
    localparam int DEBUG_RET_BIT = 30;
    // ---------------------------------------------------------------
    // cache geometry (log2 sizes) and divide step count
    // ---------------------------------------------------------------
    localparam int BLOCK_BITS = 4;
    localparam int CACHE_BITS = 12;
    localparam int WAY_BITS = 1;
    localparam int DIV_STEPS = 32;

    typedef enum logic [3:0] {
        CCD_CACHE_NONE = 4'h0,
        CCD_IDX_INV = 4'h1,
        CCD_IDX_LRU = 4'h2,
        CCD_IDX_LOCK = 4'h4,
        CCD_HIT_INV = 4'h8
    } ccd_cache_op_e;

    typedef struct packed {
        logic valid;
        ccd_cache_op_e op;
        logic [31:0] vaddr;
        logic [CACHE_BITS-1:0] index;
    } ccd_cache_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] unit;
        logic [4:0] regno;
        logic [31:0] data;
    } ccd_cop_req_s;

    typedef enum logic [1:0] {
        CCD_DIV_IDLE = 2'b01,
        CCD_DIV_RUN = 2'b10
    } ccd_div_state_e;
endpackage

// *** rtl/ccd_exec.sv ***
/*
 decode and execute for cache maintenance, coprocessor control moves,
 coprocessor operate, debug exception return and divide.
 assumes the pipeline gives instruction, operands and usable flags each
 issue cycle, and that address translation and caches sit outside.
*/
// Our own choices: the register offsets and strobed register access.
// How it works
// (RULE1) cache address is sign-extended 16-bit offset plus base, then translated
// (RULE2) the 5-bit op field picks the cache action
// (RULE3) system coprocessor unusable: no cache action, unusable exception
// (RULE4) bits 17:16 pick icache 00, dcache 01; 10 and 11 reserved
// (RULE5) op 000 on icache invalidates the indexed block
// (RULE6) software issues icache index invalidate only with icache enable bit 0
// (RULE7) op 001 on dcache clears the indexed set's recency bit
// (RULE8) op 010 on dcache clears the indexed set's pin bit
// (RULE9) op 100 on dcache looks up address and invalidates on hit
// (RULE10) address-match op on miss or invalid block does nothing
// (RULE11) index ops take index bits straight from address, no tag compare
// (RULE12) read control: coprocessor z control rd goes to rt, not system coproc
// (RULE13) write control: rt goes to coprocessor z control rd, low 11 bits zero
// (RULE14) operate passes 25-bit function only to the coprocessor
// (RULE15) debug return: opcode 010000, bit 25 set, function 011111
// (RULE16) debug return acts as delayed branch, pc loads one cycle later
// (RULE17) on return pc takes debug return address, debug bit 30 cleared
// (RULE18) software keeps debug return out of delay slots and spaced after writes
// (RULE19) signed divide: quotient and remainder registers, no overflow trap
// (RULE20) unsigned divide treats operands zero-extended
// (RULE21) divide runs alongside pipeline; early result reads stall
// (RULE22) software spaces result reads two instructions before a divide
// (RULE23) iterative divider keeps a busy flag driving the interlock
`timescale 1ns/1ps
module ccd_exec #(
    parameter int DIV_CYCLES = ccd_pkg::DIV_STEPS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue,
    input wire logic [31:0] instr,
    input wire logic [31:0] rs_val,
    input wire logic [31:0] rt_val,
    input wire logic [3:0] cop_usable,
    input wire logic [31:0] debug_return_addr_reg,
    input wire logic in_delay_slot,
    input wire logic [31:0] cop_ctrl_rdata,
    input wire logic stall_in,
    output ccd_pkg::ccd_cache_req_s cache_req,
    output ccd_pkg::ccd_cop_req_s cop_req,
    output logic cop_operate_valid,
    output logic [24:0] cop_operate_fn,
    output logic cop_unusable_exc,
    output logic [1:0] cop_unusable_unit,
    output logic gpr_we,
    output logic [4:0] gpr_waddr,
    output logic [31:0] gpr_wdata,
    output logic pc_load,
    output logic [31:0] pc_value,
    output logic debug_bit_clear,
    output logic [31:0] quotient_result_reg,
    output logic [31:0] remainder_result_reg,
    output logic div_busy,
    output logic interlock_stall
);
    import ccd_pkg::*;

    // ---------------------------------------------------------------
    // field decode
    // ---------------------------------------------------------------
    wire logic [5:0] opc = instr[OPC_HI:OPC_LO];
    wire logic [5:0] fn = instr[5:0];
    wire logic [4:0] cache_field = instr[CACHE_OP_HI:CACHE_OP_LO]; // see RULE2
    wire logic [1:0] cache_tgt = cache_field[1:0]; // see RULE4
    wire logic [2:0] cache_code = cache_field[4:2]; // see RULE5
    wire logic is_cop = (opc[5:2] == OPC_COP_HI);
    wire logic [1:0] cop_unit = opc[1:0];
    wire logic [4:0] cop_sub = instr[25:21];
    wire logic is_cache = issue && (opc == OPC_CACHE);
    wire logic is_cf = issue && is_cop && !instr[CO_BIT] && (cop_sub == SUB_CF)
        && (instr[10:0] == CTL_LOW_ZERO) && (cop_unit != 2'h0); // see RULE12
    wire logic is_ct = issue && is_cop && !instr[CO_BIT] && (cop_sub == SUB_CT)
        && (instr[10:0] == CTL_LOW_ZERO) && (cop_unit != 2'h0); // see RULE13
    wire logic is_dret = issue && (opc == {OPC_COP_HI, 2'h0}) && instr[CO_BIT]
        && (instr[24:6] == DBG_RET_ZERO) && (fn == FN_DBG_RET); // see RULE15
    wire logic is_coop = issue && is_cop && instr[CO_BIT] && !is_dret && (cop_unit != 2'h0);
    wire logic is_div = issue && (opc == OPC_SPECIAL) && (fn == FN_DIV);
    wire logic is_unsigned_quotient_op = issue && (opc == OPC_SPECIAL) && (fn == FN_UNSIGNED_QUOTIENT_OP);
    wire logic is_res_read = issue && (opc == OPC_SPECIAL) && ((fn == 6'h10) || (fn == 6'h12));
    wire logic is_mac = issue && (opc == 6'h1C) && ((fn == 6'h00) || (fn == 6'h01));

    // ---------------------------------------------------------------
    // usability
    // ---------------------------------------------------------------
    wire logic sys_ok = cop_usable[0];
    wire logic unit_ok = cop_usable[cop_unit];
    wire logic need_sys = is_cache || is_dret;
    wire logic need_unit = is_cf || is_ct || is_coop;
    wire logic unusable = (need_sys && !sys_ok) || (need_unit && !unit_ok); // see RULE3
    wire logic [1:0] unusable_unit = need_sys ? 2'h0 : cop_unit;

    // ---------------------------------------------------------------
    // cache request
    // ---------------------------------------------------------------
    wire logic [31:0] cache_vaddr = rs_val + {{16{instr[15]}}, instr[15:0]}; // see RULE1
    wire logic [CACHE_BITS-1:0] set_index = {
        {(WAY_BITS + BLOCK_BITS){1'b0}},
        cache_vaddr[CACHE_BITS-WAY_BITS-1:BLOCK_BITS]}; // see RULE11
    wire logic [CACHE_BITS-1:0] blk_index = {
        {BLOCK_BITS{1'b0}}, cache_vaddr[CACHE_BITS-1:BLOCK_BITS]}; // see RULE11
    ccd_cache_op_e next_cache_op;
    always_comb begin
        next_cache_op = CCD_CACHE_NONE; // reserved targets and codes do nothing, see RULE4
        if (cache_tgt == TGT_ICACHE && cache_code == COP_IDX_INV)
            next_cache_op = CCD_IDX_INV; // see RULE5
        else if (cache_tgt == TGT_DCACHE && cache_code == COP_IDX_LRU)
            next_cache_op = CCD_IDX_LRU; // see RULE7
        else if (cache_tgt == TGT_DCACHE && cache_code == COP_IDX_LOCK)
            next_cache_op = CCD_IDX_LOCK; // see RULE8
        else if (cache_tgt == TGT_DCACHE && cache_code == COP_HIT_INV)
            next_cache_op = CCD_HIT_INV; // see RULE9
    end
    // hit invalidate goes to the cache as a normal lookup; a miss leaves it untouched
    wire ccd_cache_req_s next_cache_req = '{
        valid: is_cache && sys_ok && (next_cache_op != CCD_CACHE_NONE), // see RULE3
        op: next_cache_op,
        vaddr: cache_vaddr, // see RULE10
        index: (next_cache_op == CCD_IDX_INV) ? blk_index : set_index};

    // ---------------------------------------------------------------
    // coprocessor moves and operate
    // ---------------------------------------------------------------
    wire ccd_cop_req_s next_cop_req = '{
        valid: (is_cf || is_ct) && unit_ok,
        write: is_ct, // see RULE13
        unit: cop_unit,
        regno: instr[15:11],
        data: rt_val};

    // ---------------------------------------------------------------
    // debug return: armed at issue, pc loads after the delay slot
    // ---------------------------------------------------------------
    logic dret_armed;
    logic [31:0] dret_target;
    wire logic dret_take = is_dret && sys_ok && !in_delay_slot;

    // ---------------------------------------------------------------
    // divider: restoring, one bit per cycle
    // ---------------------------------------------------------------
    ccd_div_state_e div_state;
    logic [31:0] div_q;
    logic [32:0] div_r;
    logic [31:0] div_d;
    logic div_neg_q;
    logic div_neg_r;
    logic [5:0] div_cnt;
    wire logic div_start = (is_div || is_unsigned_quotient_op) && (div_state == CCD_DIV_IDLE);
    wire logic [31:0] abs_rs = (is_div && rs_val[31]) ? (32'h0 - rs_val) : rs_val; // see RULE20
    wire logic [31:0] abs_rt = (is_div && rt_val[31]) ? (32'h0 - rt_val) : rt_val;
    wire logic [32:0] shl_r = {div_r[31:0], div_q[31]};
    wire logic [32:0] trial = shl_r - {1'b0, div_d};
    wire logic [32:0] next_div_r = trial[32] ? shl_r : trial;
    wire logic [31:0] next_div_q = {div_q[30:0], ~trial[32]};
    wire logic div_last = (div_cnt == 6'(DIV_CYCLES - 1));
    wire logic [31:0] fin_q = div_neg_q ? (32'h0 - next_div_q) : next_div_q; // see RULE19
    wire logic [31:0] fin_r = div_neg_r ? (32'h0 - next_div_r[31:0]) : next_div_r[31:0];
    wire logic div_running = (div_state == CCD_DIV_RUN);
    // a second divide while busy waits, as does any result read, except in the last step cycle
    wire logic next_stall = div_running && (is_res_read || is_mac || is_div || is_unsigned_quotient_op); // see RULE21

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cache_req <= '0;
            cop_req <= '0;
            cop_operate_valid <= 1'b0;
            cop_operate_fn <= 25'h0000000;
            cop_unusable_exc <= 1'b0;
            cop_unusable_unit <= 2'h0;
            gpr_we <= 1'b0;
            gpr_waddr <= 5'h00;
            gpr_wdata <= 32'h00000000;
        end else begin
            cache_req <= next_cache_req;
            cop_req <= next_cop_req;
            cop_operate_valid <= is_coop && unit_ok; // see RULE14
            cop_operate_fn <= instr[24:0]; // see RULE14
            cop_unusable_exc <= unusable; // see RULE3
            cop_unusable_unit <= unusable_unit;
            gpr_we <= is_cf && unit_ok;
            gpr_waddr <= instr[20:16];
            gpr_wdata <= cop_ctrl_rdata; // see RULE12
        end
    end

    // the slot instruction issues between arming and the pc load, see RULE16
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dret_armed <= 1'b0;
            dret_target <= 32'h00000000;
            pc_load <= 1'b0;
            pc_value <= 32'h00000000;
            debug_bit_clear <= 1'b0;
        end else begin
            if (dret_take) begin
                dret_armed <= 1'b1;
                dret_target <= debug_return_addr_reg; // see RULE17
            end else if (dret_armed && issue) begin
                dret_armed <= 1'b0;
            end
            pc_load <= dret_armed && issue; // see RULE16
            pc_value <= dret_target; // see RULE17
            debug_bit_clear <= dret_armed && issue; // see RULE17
        end
    end

    // divider keeps stepping through pipeline stalls, see RULE21
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_state <= CCD_DIV_IDLE;
            div_q <= 32'h00000000;
            div_r <= 33'h000000000;
            div_d <= 32'h00000000;
            div_neg_q <= 1'b0;
            div_neg_r <= 1'b0;
            div_cnt <= 6'h00;
            quotient_result_reg <= 32'h00000000;
            remainder_result_reg <= 32'h00000000;
            div_busy <= 1'b0;
            interlock_stall <= 1'b0;
        end else begin
            unique case (div_state)
                CCD_DIV_IDLE: begin
                    if (div_start) begin
                        div_state <= CCD_DIV_RUN;
                        div_q <= abs_rs;
                        div_r <= 33'h000000000;
                        div_d <= abs_rt;
                        div_neg_q <= is_div && (rs_val[31] ^ rt_val[31]);
                        div_neg_r <= is_div && rs_val[31];
                        div_cnt <= 6'h00;
                        div_busy <= 1'b1; // see RULE23
                    end
                end
                CCD_DIV_RUN: begin
                    div_q <= next_div_q;
                    div_r <= next_div_r;
                    div_cnt <= div_cnt + 6'h01;
                    if (div_last) begin
                        div_state <= CCD_DIV_IDLE;
                        quotient_result_reg <= fin_q; // see RULE19
                        remainder_result_reg <= fin_r; // see RULE20
                        div_busy <= 1'b0; // see RULE23
                    end
                end
            endcase
            interlock_stall <= next_stall && !div_last; // see RULE23
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    cache_block_a: assert property (is_cache && !sys_ok |=> !cache_req.valid && cop_unusable_exc) // see RULE3
        else $error("cache op acted without system coprocessor");
    cache_addr_a: assert property (is_cache && sys_ok && next_cache_op != CCD_CACHE_NONE // see RULE1
        |=> cache_req.valid && cache_req.vaddr == $past(rs_val) + {{16{$past(instr[15])}}, $past(instr[15:0])})
        else $error("cache address wrong");
    cache_tgt_a: assert property (is_cache && instr[17] |=> !cache_req.valid) // see RULE4
        else $error("reserved cache target acted");
    icache_inv_a: assert property (is_cache && sys_ok && cache_field == 5'h00
        |=> cache_req.op == CCD_IDX_INV) // see RULE5
        else $error("icache invalidate not issued");
    dcache_lru_a: assert property (is_cache && sys_ok && cache_field == 5'h05
        |=> cache_req.op == CCD_IDX_LRU) // see RULE7
        else $error("recency clear not issued");
    dcache_pin_a: assert property (is_cache && sys_ok && cache_field == 5'h09
        |=> cache_req.op == CCD_IDX_LOCK) // see RULE8
        else $error("pin clear not issued");
    hit_inv_a: assert property (is_cache && sys_ok && cache_field == 5'h11
        |=> cache_req.op == CCD_HIT_INV) // see RULE9
        else $error("match invalidate not issued");
    ctl_read_a: assert property (is_cf && unit_ok |=> gpr_we && gpr_waddr == $past(instr[20:16])) // see RULE12
        else $error("control read not written back");
    ctl_write_a: assert property (is_ct && unit_ok |=> cop_req.valid && cop_req.write) // see RULE13
        else $error("control write lost");
    cop_fn_a: assert property (is_coop && unit_ok |=> cop_operate_valid && !gpr_we && !cache_req.valid) // see RULE14
        else $error("operate touched core state");
    dret_pc_a: assert property (dret_take ##1 issue |=> pc_load && debug_bit_clear) // see RULE16
        else $error("debug return pc not loaded");
    dret_addr_a: assert property (dret_take ##1 issue |=> pc_value == $past(debug_return_addr_reg, 2)) // see RULE17
        else $error("debug return target wrong");
    div_busy_a: assert property (div_start |=> div_busy [*8]) // see RULE23
        else $error("divider not busy");
    div_stall_a: assert property (div_busy && (is_res_read || is_mac) && !div_last |=> interlock_stall) // see RULE21
        else $error("early result read not stalled");
    div_done_a: assert property (div_start |-> ##[1:40] !div_busy) // see RULE19
        else $error("divide never finished");

    div_cover_c: cover property (div_start ##[1:40] !div_busy);
    dret_cover_c: cover property (dret_take ##1 issue ##1 pc_load);
    cache_cover_c: cover property (cache_req.valid && cache_req.op == CCD_HIT_INV);
    stall_cover_c: cover property (interlock_stall);
endmodule // ccd_exec

// *** verif/ccd_far_side.sv ***
/*
 behavioural model of the attached coprocessors: control register files
 answering read-control and taking write-control.
 assumes one core clock and the decoded instruction seen by the block.
*/
`timescale 1ns/1ps
module ccd_far_side (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [31:0] instr,
    input wire ccd_pkg::ccd_cop_req_s cop_req,
    output logic [31:0] cop_ctrl_rdata
);
    import ccd_pkg::*;
    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [31:0] ctrl [4][32];
    logic [31:0] junk;
    wire logic is_read;
    assign is_read = (instr[31:28] == OPC_COP_HI) && (instr[25:21] == SUB_CF);
    // unselected bus shows a changing pattern, never a stale value
    assign cop_ctrl_rdata = is_read ? ctrl[instr[27:26]][instr[15:11]] : junk;
    always_ff @(posedge core_clk) begin
        junk <= rst ? 32'hA5A5_0F0F : ~junk;
        if (cop_req.valid && cop_req.write) begin
            ctrl[cop_req.unit][cop_req.regno] <= cop_req.data;
        end
    end
    // operate pulses change nothing that the block can see
endmodule // ccd_far_side

// *** verif/tb_top.sv ***
/*
 self-checking bench for the cache, coprocessor and divide execute block.
 assumes the far-side model file and the design package are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
    import ccd_pkg::*;
    logic core_clk, rst, issue, in_delay_slot, stall_in;
    logic [31:0] instr, rs_val, rt_val, debug_return_addr_reg, cop_ctrl_rdata;
    logic [3:0] cop_usable;
    ccd_cache_req_s cache_req, last_cache;
    ccd_cop_req_s cop_req, last_cop;
    logic cop_operate_valid, cop_unusable_exc, gpr_we, pc_load, debug_bit_clear, div_busy, interlock_stall;
    logic [24:0] cop_operate_fn, last_fn;
    logic [1:0] cop_unusable_unit, last_uu;
    logic [4:0] gpr_waddr;
    logic [31:0] gpr_wdata, pc_value, quotient_result_reg, remainder_result_reg, last_pc, last_gd, seed;
    int err_total, checked, n_cache, n_cop, n_op, n_exc, n_gpr, n_pc, n_dbg, n_stall, n_busy;

    ccd_exec #(.DIV_CYCLES(32)) ccd_exec_inst (.core_clk(core_clk), .rst(rst), .issue(issue),
        .instr(instr), .rs_val(rs_val), .rt_val(rt_val), .cop_usable(cop_usable),
        .debug_return_addr_reg(debug_return_addr_reg), .in_delay_slot(in_delay_slot),
        .cop_ctrl_rdata(cop_ctrl_rdata), .stall_in(stall_in), .cache_req(cache_req), .cop_req(cop_req),
        .cop_operate_valid(cop_operate_valid), .cop_operate_fn(cop_operate_fn),
        .cop_unusable_exc(cop_unusable_exc), .cop_unusable_unit(cop_unusable_unit), .gpr_we(gpr_we),
        .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .pc_load(pc_load), .pc_value(pc_value),
        .debug_bit_clear(debug_bit_clear), .quotient_result_reg(quotient_result_reg),
        .remainder_result_reg(remainder_result_reg), .div_busy(div_busy), .interlock_stall(interlock_stall));
    ccd_far_side ccd_far_side_inst (.core_clk(core_clk), .rst(rst), .instr(instr), .cop_req(cop_req),
        .cop_ctrl_rdata(cop_ctrl_rdata));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [63:0] div_ref(input logic [31:0] a, b, input logic sg);
        if (sg) begin
            return {$signed(a) % $signed(b), $signed(a) / $signed(b)};
        end
        return {a % b, a / b};
    endfunction
    task automatic chk_word(input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_cnt(input int e, g);
        checked++;
        if (g != e) begin
            err_total++;
            $display("unexpected count at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic put(input logic [31:0] i, a, b);
        @(posedge core_clk);
        issue <= 1'b1;
        instr <= i;
        rs_val <= a;
        rt_val <= b;
    endtask
    task automatic settle();
        repeat (4) begin
            @(posedge core_clk);
            issue <= 1'b0;
        end
        #1;
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // pulse monitors: outputs are registered, so sample at the edge
    always @(posedge core_clk) begin
        if (cache_req.valid === 1'b1) begin n_cache++; last_cache = cache_req; end
        if (cop_req.valid === 1'b1) begin n_cop++; last_cop = cop_req; end
        if (cop_operate_valid === 1'b1) begin n_op++; last_fn = cop_operate_fn; end
        if (cop_unusable_exc === 1'b1) begin n_exc++; last_uu = cop_unusable_unit; end
        if (gpr_we === 1'b1) begin n_gpr++; last_gd = gpr_wdata; end
        if (pc_load === 1'b1) begin n_pc++; last_pc = pc_value; end
        if (debug_bit_clear === 1'b1) n_dbg++;
        if (interlock_stall === 1'b1) n_stall++;
        if (div_busy === 1'b1) n_busy++;
    end

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #(25 * 20000);
        err_total++;
        end_of_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [4:0] ops [6];
        logic [3:0] eops [4];
        logic [31:0] a, b, d, da [2], db [2];
        logic [63:0] r;
        int n0, n1, n2;
        ops = '{5'h00, 5'h05, 5'h09, 5'h11, 5'h02, 5'h03};
        eops = '{CCD_IDX_INV, CCD_IDX_LRU, CCD_IDX_LOCK, CCD_HIT_INV};
        da = '{32'hFFFF_FFF9, 32'hFFFF_FFFF};
        db = '{32'h0000_0002, 32'h0000_0003};
        seed = 32'h0000_004F;
        rst = 1'b1; issue = 1'b0; instr = 32'h0; rs_val = 32'h0; rt_val = 32'h0;
        cop_usable = 4'hF; in_delay_slot = 1'b0; stall_in = 1'b0;
        debug_return_addr_reg = 32'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // cache ops; icache treated as disabled by software
        for (int k = 0; k < 6; k++) begin
            a = rnd();
            b = rnd();
            n0 = n_cache;
            put({OPC_CACHE, 5'h03, ops[k], a[15:0]}, b, 32'h0);
            settle();
            chk_cnt(n0 + (k < 4 ? 1 : 0), n_cache);
            if (k < 4) begin
                chk_word({28'h0, eops[k]}, {28'h0, last_cache.op});
                chk_word(b + {{16{a[15]}}, a[15:0]}, last_cache.vaddr);
                d = b + {{16{a[15]}}, a[15:0]};
                chk_word(k == 0 ? {24'h0, d[11:4]} : {25'h0, d[10:4]}, {20'h0, last_cache.index});
            end
        end
        @(posedge core_clk);
        cop_usable <= 4'hE;
        n0 = n_cache;
        n1 = n_exc;
        put({OPC_CACHE, 5'h03, 5'h11, 16'h8010}, rnd(), 32'h0);
        settle();
        chk_cnt(n0, n_cache);
        chk_cnt(n1 + 1, n_exc);
        chk_word(32'h0, {30'h0, last_uu});
        cop_usable <= 4'hF;
        // coprocessor moves and operate
        for (int z = 1; z < 4; z++) begin
            d = rnd();
            a = rnd();
            put({OPC_COP_HI, z[1:0], SUB_CT, 5'h07, a[4:0], CTL_LOW_ZERO}, 32'h0, d);
            settle();
            chk_word({1'b1, z[1:0], a[4:0], d}, {last_cop.write, last_cop.unit, last_cop.regno, last_cop.data});
            n0 = n_gpr;
            put({OPC_COP_HI, z[1:0], SUB_CF, 5'h09, a[4:0], CTL_LOW_ZERO}, 32'h0, 32'h0);
            settle();
            chk_cnt(n0 + 1, n_gpr);
            chk_word(d, last_gd);
            chk_word({27'h0, 5'h09}, {27'h0, gpr_waddr});
            n0 = n_cop;
            n1 = n_cache;
            n2 = n_op;
            put({OPC_COP_HI, z[1:0], 1'b1, a[24:0]}, 32'h0, 32'h0);
            settle();
            chk_word({7'h0, a[24:0]}, {7'h0, last_fn});
            chk_cnt(n2 + 1, n_op);
            chk_cnt(n0 + n1, n_cop + n_cache);
        end
        n0 = n_gpr;
        put({OPC_COP_HI, 2'h0, SUB_CF, 5'h09, 5'h01, CTL_LOW_ZERO}, 32'h0, 32'h0);
        settle();
        chk_cnt(n0, n_gpr);
        // debug return: address set once, one cycle before the first return; once outside a slot and once from a slot, which must not load
        debug_return_addr_reg <= rnd() & 32'hFFFF_FFFC;
        for (int k = 0; k < 2; k++) begin
            n0 = n_pc;
            n1 = n_dbg;
            in_delay_slot <= k[0];
            put({OPC_COP_HI, 2'h0, 1'b1, DBG_RET_ZERO, FN_DBG_RET}, 32'h0, 32'h0);
            put(32'h0, 32'h0, 32'h0);
            in_delay_slot <= 1'b0;
            settle();
            chk_cnt(n0 + 1 - k, n_pc);
            chk_cnt(n1 + 1 - k, n_dbg);
            if (k == 0) chk_word(debug_return_addr_reg, last_pc);
        end
        // divides, two corners then random; each followed at once by a result read or multiply-add, which stalls
        for (int k = 0; k < 8; k++) begin
            a = k < 2 ? da[k] : rnd();
            b = k < 2 ? db[k] : ((rnd() >> 1) | 32'h1);
            n0 = n_busy;
            n1 = n_stall;
            put({OPC_SPECIAL, 20'h0, k[0] ? FN_UNSIGNED_QUOTIENT_OP : FN_DIV}, a, b);
            put(k[1] ? 32'h7000_0000 : (k[2] ? 32'h0000_0010 : 32'h0000_0012), 32'h0, 32'h0);
            n2 = 0;
            do begin
                @(posedge core_clk);
                issue <= 1'b0;
                stall_in <= rnd() > 32'h8000_0000;
                n2++;
            end while (div_busy !== 1'b0 && n2 < 60);
            chk_cnt(DIV_STEPS + 1, n2);
            settle();
            r = div_ref(a, b, !k[0]);
            chk_word(r[31:0], quotient_result_reg);
            chk_word(r[63:32], remainder_result_reg);
            chk_cnt(n0 + 32, n_busy);
            chk_cnt(n1 + 1, n_stall);
        end
        end_of_test();
    end
endmodule // tb_top
